/* rdc_radar_timing.sv */
// radar support logic: converter, reference chain, tilt, heater, bus slave
`timescale 1ns/1ns
module rdc_radar_timing #(
  parameter int MOVE_LIMIT = rdc_pkg::MOVE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rdc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rdc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [rdc_pkg::NUM_IN-1:0] pulse_rate_input,
  input wire logic [rdc_pkg::SEL_W-1:0] input_select,
  input wire logic count_window,
  input wire logic readout_cmd,
  input wire logic readout_clk,
  output logic serial_pos,
  output logic serial_neg,
  input wire logic master_osc,
  input wire logic ref_clk_3k2,
  output logic osc_speed_up,
  output logic osc_speed_down,
  output logic ref_locked,
  output logic sub_fc,
  output logic sub_fc_a,
  output logic sub_fc_b,
  output logic sub_fc_c,
  input wire logic self_test_sw,
  output logic vel_test_tone,
  output logic alt_test_tone,
  input wire logic [1:0] antenna_selector,
  input wire logic tilt_cmd,
  input wire logic limit_pos1,
  input wire logic limit_pos2,
  output logic drive_pos1,
  output logic drive_pos2,
  input wire logic sense_pos1,
  input wire logic sense_pos2,
  output logic pos1_ind,
  output logic pos2_ind,
  input wire logic [rdc_pkg::TEMP_W-1:0] antenna_temp,
  input wire logic main_pwr,
  output logic heater_on,
  input wire logic range_good,
  input wire logic vel_good,
  input wire logic range_scale,
  output logic range_valid_ind,
  output logic vel_valid_ind,
  output logic range_scale_ind
);
  import rdc_pkg::*;

  localparam int TMR_W = $clog2(MOVE_LIMIT + 1);
  localparam int BIT_A = $clog2(FC_DIV_A) - 1;
  localparam int BIT_B = $clog2(FC_DIV_B) - 1;
  localparam int BIT_C = $clog2(FC_DIV_C) - 1;
  localparam int MOD_W = $clog2(MO_DIV);
  localparam int NSYNC = NUM_IN + SEL_W + 17;

  if (MOVE_LIMIT < 2) begin : g_bad_move
    $error("rdc_radar_timing: MOVE_LIMIT must be at least 2");
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // temperature bits are synchronised as a bus: it drifts far slower
  // than the clock, so a split sample is rare and lasts one clock at worst
  logic [NSYNC-1:0] pin_meta_ff;
  logic [NSYNC-1:0] pin_sync_ff;
  logic [NSYNC-1:0] pins;
  logic [NUM_IN-1:0] pri_s;
  logic [SEL_W-1:0] sel_s;
  logic win_s, rd_s, rclk_s, mo_s, ref_s, test_s, cmd_s;
  logic lim1_s, lim2_s, sns1_s, sns2_s, pwr_s, rg_s, vg_s, rs_s;
  logic [1:0] asel_s;
  logic [TEMP_W-1:0] temp_s;

  assign pins = {pulse_rate_input, input_select, count_window, readout_cmd,
                 readout_clk, master_osc, ref_clk_3k2, self_test_sw, tilt_cmd,
                 limit_pos1, limit_pos2, sense_pos1, sense_pos2, main_pwr,
                 range_good, vel_good, range_scale, antenna_selector};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pins;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign {pri_s, sel_s, win_s, rd_s, rclk_s, mo_s, ref_s, test_s, cmd_s,
          lim1_s, lim2_s, sns1_s, sns2_s, pwr_s, rg_s, vg_s, rs_s,
          asel_s} = pin_sync_ff;

  logic [TEMP_W-1:0] temp_meta_ff;
  logic [TEMP_W-1:0] temp_sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_meta_ff <= '0;
      temp_sync_ff <= '0;
    end else begin
      temp_meta_ff <= antenna_temp;
      temp_sync_ff <= temp_meta_ff;
    end
  end
  assign temp_s = temp_sync_ff;

  // edge detection on the synchronised copies only
  logic [NUM_IN-1:0] pri_d_ff;
  logic rclk_d_ff, mo_d_ff, ref_d_ff;
  logic [NUM_IN-1:0] pri_rise;
  logic rclk_rise, mo_rise, ref_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pri_d_ff <= '0;
      rclk_d_ff <= 1'b0;
      mo_d_ff <= 1'b0;
      ref_d_ff <= 1'b0;
    end else begin
      pri_d_ff <= pri_s;
      rclk_d_ff <= rclk_s;
      mo_d_ff <= mo_s;
      ref_d_ff <= ref_s;
    end
  end

  assign pri_rise = pri_s & ~pri_d_ff;
  assign rclk_rise = rclk_s & ~rclk_d_ff;
  assign mo_rise = mo_s & ~mo_d_ff;
  assign ref_rise = ref_s & ~ref_d_ff;

  // ---------------------------------------------------------------
  // serial word converter
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] last_word;

  rdc_converter #(.WIDTH(WORD_W)) u_conv (
    .aclk(aclk),
    .aresetn(aresetn),
    .pulse(pri_rise[sel_s]),
    .gate_open(win_s),
    .readout(rd_s),
    .shift_step(rclk_rise),
    .ser_p(serial_pos),
    .ser_n(serial_neg),
    .last_word(last_word)
  );

  // ---------------------------------------------------------------
  // reference chain
  // ---------------------------------------------------------------
  logic [MOD_W-1:0] mo_cnt_ff;
  logic [FCD_W-1:0] fc_cnt_ff;
  logic fc_d_ff;
  logic fc_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mo_cnt_ff <= '0;
      fc_d_ff <= 1'b0;
    end else begin
      if (mo_rise) begin
        mo_cnt_ff <= mo_cnt_ff + 1'b1;
      end
      fc_d_ff <= mo_cnt_ff[MOD_W-1];
    end
  end
  assign fc_rise = mo_cnt_ff[MOD_W-1] & ~fc_d_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fc_cnt_ff <= '0;
    end else if (fc_rise) begin
      fc_cnt_ff <= fc_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_fc <= 1'b0;
      sub_fc_a <= 1'b0;
      sub_fc_b <= 1'b0;
      sub_fc_c <= 1'b0;
    end else begin
      sub_fc <= mo_cnt_ff[MOD_W-1];
      sub_fc_a <= fc_cnt_ff[BIT_A];
      sub_fc_b <= fc_cnt_ff[BIT_B];
      sub_fc_c <= fc_cnt_ff[BIT_C];
    end
  end

  // master edges per reference period steer the oscillator control
  logic [REF_W-1:0] ref_cnt_ff;
  logic [REF_W-1:0] ref_meas_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_ff <= '0;
      ref_meas_ff <= '0;
      osc_speed_up <= 1'b0;
      osc_speed_down <= 1'b0;
      ref_locked <= 1'b0;
    end else if (ref_rise) begin
      ref_cnt_ff <= {{(REF_W-1){1'b0}}, mo_rise};
      ref_meas_ff <= ref_cnt_ff;
      osc_speed_up <= ref_cnt_ff < REF_W'(REF_RATIO);
      osc_speed_down <= ref_cnt_ff > REF_W'(REF_RATIO);
      ref_locked <= ref_cnt_ff == REF_W'(REF_RATIO);
    end else if (mo_rise && !(&ref_cnt_ff)) begin
      ref_cnt_ff <= ref_cnt_ff + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // self test tones
  // ---------------------------------------------------------------
  logic [1:0] ctrl_ff;
  logic test_active;

  assign test_active = test_s | ctrl_ff[CTRL_TEST_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vel_test_tone <= 1'b0;
      alt_test_tone <= 1'b0;
    end else begin
      vel_test_tone <= test_active & fc_cnt_ff[BIT_C];
      alt_test_tone <= test_active & fc_cnt_ff[BIT_B];
    end
  end

  a_test_tones: assert property (@(posedge aclk) disable iff (!aresetn)
    !test_active |=> !vel_test_tone && !alt_test_tone)
    else $error("test tone out while test is off");

  // ---------------------------------------------------------------
  // antenna tilt
  // ---------------------------------------------------------------
  rdc_tilt_e tilt_ff;
  logic target2_ff;
  logic move_late_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic want2;
  logic at_want;
  logic at_target;

  assign want2 = (asel_s == SEL_POS2) || ((asel_s == SEL_AUTO) && cmd_s);
  assign at_want = want2 ? lim2_s : lim1_s;
  assign at_target = target2_ff ? lim2_s : lim1_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tilt_ff <= TILT_IDLE;
      target2_ff <= 1'b0;
      tmr_ff <= '0;
      move_late_ff <= 1'b0;
    end else begin
      case (tilt_ff)
        TILT_IDLE: begin
          tmr_ff <= '0;
          if (!at_want && (!move_late_ff || (want2 != target2_ff))) begin
            tilt_ff <= TILT_MOVE;
            target2_ff <= want2;
            move_late_ff <= 1'b0;
          end
        end
        TILT_MOVE: begin
          tmr_ff <= tmr_ff + 1'b1;
          if (at_target || (want2 != target2_ff)) begin
            tilt_ff <= TILT_IDLE;
            tmr_ff <= '0;
          end else if (tmr_ff == TMR_W'(MOVE_LIMIT - 1)) begin
            tilt_ff <= TILT_IDLE;
            tmr_ff <= '0;
            move_late_ff <= 1'b1;
          end
        end
        default: begin
          tilt_ff <= TILT_IDLE;
        end
      endcase
    end
  end

  // a timed-out move stays stopped until the request changes
  assign drive_pos1 = (tilt_ff == TILT_MOVE) && !target2_ff && !move_late_ff;
  assign drive_pos2 = (tilt_ff == TILT_MOVE) && target2_ff && !move_late_ff;

  a_drive_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
    !(drive_pos1 && drive_pos2)) else $error("both tilt lines driven");
  a_drive_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    (drive_pos1 && lim1_s) |=> !drive_pos1)
    else $error("drive held at position limit");
  a_move_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    tmr_ff < TMR_W'(MOVE_LIMIT)) else $error("move ran past its time");

  // ---------------------------------------------------------------
  // position and status discretes
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos1_ind <= 1'b0;
      pos2_ind <= 1'b0;
      range_valid_ind <= 1'b0;
      vel_valid_ind <= 1'b0;
      range_scale_ind <= 1'b0;
    end else begin
      pos1_ind <= sns1_s;
      pos2_ind <= sns2_s;
      range_valid_ind <= rg_s;
      vel_valid_ind <= vg_s;
      range_scale_ind <= rs_s;
    end
  end

  a_pos_ind: assert property (@(posedge aclk) disable iff (!aresetn)
    pos1_ind == $past(sns1_s) && pos2_ind == $past(sns2_s))
    else $error("position indication does not follow contacts");

  // ---------------------------------------------------------------
  // heater
  // ---------------------------------------------------------------
  logic signed [TEMP_W-1:0] temp_sv;
  assign temp_sv = temp_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      heater_on <= 1'b0;
    end else if (pwr_s || ctrl_ff[CTRL_HINH_BIT]) begin
      heater_on <= 1'b0;
    end else if (temp_sv <= HEAT_ON_F) begin
      heater_on <= 1'b1;
    end else if (temp_sv >= HEAT_OFF_F) begin
      heater_on <= 1'b0;
    end
  end

  a_heater_pwr: assert property (@(posedge aclk) disable iff (!aresetn)
    pwr_s |=> !heater_on) else $error("heater on with radar powered");
  a_heater_hyst: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pwr_s && !ctrl_ff[CTRL_HINH_BIT] && temp_sv > HEAT_ON_F
     && temp_sv < HEAT_OFF_F) |=> heater_on == $past(heater_on))
    else $error("heater changed inside band");

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'h0};
    return (w == A_CTRL) || (w == A_STATUS) || (w == A_WORD) || (w == A_REFMEAS);
  endfunction

  logic aw_got_ff, w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic [ADDR_W-1:0] ar_word;

  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_word = {s_axi_araddr[ADDR_W-1:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_ff <= CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (aw_got_ff && w_got_ff && !s_axi_bvalid) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
        if ({awaddr_ff[ADDR_W-1:2], 2'h0} == A_CTRL && wstrb0_ff) begin
          ctrl_ff <= wdata_ff[1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (ar_word)
        A_CTRL: s_axi_rdata <= {30'h00000000, ctrl_ff};
        A_STATUS: s_axi_rdata <= {22'h000000, move_late_ff, ref_locked,
                                  heater_on, pos2_ind, pos1_ind, drive_pos2,
                                  drive_pos1, tilt_ff == TILT_MOVE, test_active,
                                  ser_word_busy()};
        A_WORD: s_axi_rdata <= {17'h00000, last_word};
        A_REFMEAS: s_axi_rdata <= {20'h00000, ref_meas_ff};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  function automatic logic ser_word_busy();
    return rd_s;
  endfunction
endmodule

/* rdc_pkg.sv */
// constants, types and register map of the radar data converter and timing logic
package rdc_pkg;
  localparam int WORD_W = 15;
  localparam int NUM_IN = 4;
  localparam int SEL_W = 2;
  // ---------------------------------------------------------------
  // reference chain
  // ---------------------------------------------------------------
  localparam int MO_HZ = 2457600;
  localparam int FC_HZ = 614400;
  localparam int REFCLK_HZ = 3200;
  localparam int MO_DIV = MO_HZ / FC_HZ;
  localparam int REF_RATIO = MO_HZ / REFCLK_HZ;
  localparam int REF_W = 12;
  localparam int FC_DIV_A = 4;
  localparam int FC_DIV_B = 32;
  localparam int FC_DIV_C = 64;
  localparam int FCD_W = $clog2(FC_DIV_C);
  // ---------------------------------------------------------------
  // timing, thermal
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 20000000;
  localparam int MOVE_TIME_S = 10;
  localparam int MOVE_CYCLES = int'(MOVE_TIME_S * CLK_HZ);
  localparam int TEMP_W = 10;
  localparam logic signed [TEMP_W-1:0] HEAT_ON_F = 10'sh037;
  localparam logic signed [TEMP_W-1:0] HEAT_OFF_F = 10'sh046;
  // ---------------------------------------------------------------
  // selector codes and register map
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_POS1 = 2'h0;
  localparam logic [1:0] SEL_POS2 = 2'h1;
  localparam logic [1:0] SEL_AUTO = 2'h2;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] A_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] A_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] A_WORD = 5'h08;
  localparam logic [ADDR_W-1:0] A_REFMEAS = 5'h0C;
  localparam int CTRL_TEST_BIT = 0;
  localparam int CTRL_HINH_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {TILT_IDLE, TILT_MOVE} rdc_tilt_e;
endpackage

/* rdc_converter.sv */
// serial word converter: gated pulse counter, capture and serial shifter
`timescale 1ns/1ns
module rdc_converter #(
  parameter int WIDTH = rdc_pkg::WORD_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pulse,
  input wire logic gate_open,
  input wire logic readout,
  input wire logic shift_step,
  output logic ser_p,
  output logic ser_n,
  output logic [WIDTH-1:0] last_word
);
  import rdc_pkg::*;

  if (WIDTH < 2) begin : g_bad_width
    $error("rdc_converter: WIDTH must be at least 2");
  end

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] shreg_ff;
  logic gate_d_ff;
  logic gate_close;

  assign gate_close = gate_d_ff & ~gate_open;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_d_ff <= 1'b0;
    end else begin
      gate_d_ff <= gate_open;
    end
  end

  // saturate rather than wrap: a wrapped count would read as a small value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
    end else if (gate_close) begin
      count_ff <= '0;
    end else if (gate_open && pulse && !(&count_ff)) begin
      count_ff <= count_ff + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_ff <= '0;
      last_word <= '0;
    end else if (gate_close) begin
      shreg_ff <= count_ff;
      last_word <= count_ff;
    end else if (readout && shift_step) begin
      shreg_ff <= {shreg_ff[WIDTH-2:0], 1'b0};
    end
  end

  assign ser_p = shreg_ff[WIDTH-1];
  assign ser_n = ~shreg_ff[WIDTH-1];

  a_serial_compl: assert property (@(posedge aclk) disable iff (!aresetn)
    ser_p != ser_n) else $error("serial lines not complementary");
  a_shift_readout: assert property (@(posedge aclk) disable iff (!aresetn)
    (!readout && !gate_close) |=> $stable(shreg_ff))
    else $error("shift register moved without readout");
  a_count_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !gate_open |=> count_ff == '0) else $error("counted outside window");
  a_capture_count: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_close |=> shreg_ff == $past(count_ff) && last_word == $past(count_ff))
    else $error("window end did not capture count");
  a_msb_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (readout && shift_step && !gate_close) |=> ser_p == $past(shreg_ff[WIDTH-2]))
    else $error("next bit is not the next lower bit");
endmodule

/* rdc_guidance_model.sv */
// guidance computer model: input select, count window, readout strobes, word capture
`timescale 1ns/1ns
module rdc_guidance_model (
  input wire logic aclk,
  output logic [rdc_pkg::NUM_IN-1:0] pulse_rate_input = '0,
  output logic [rdc_pkg::SEL_W-1:0] input_select = '0,
  output logic count_window = '0,
  output logic readout_cmd = '0,
  output logic readout_clk = '0,
  input wire logic serial_pos,
  input wire logic serial_neg
);
  import rdc_pkg::*;
  // shift clock stands low outside frames; 4 high + 5 low cycles (leading wait included) give a 450 ns period
  task automatic burst(input logic [NUM_IN-1:0] m, input logic c);
    @(posedge aclk);
    pulse_rate_input <= m;
    readout_clk <= c;
    repeat (4) @(posedge aclk);
    pulse_rate_input <= '0;
    readout_clk <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // one whole measurement; callers never overlap two of them
  task automatic measure(input logic [SEL_W-1:0] sel, input int n,
      output logic [WORD_W-1:0] word, output logic pair_ok);
    logic [NUM_IN-1:0] m;
    m = NUM_IN'(1) << sel;
    pair_ok = 1'b1;
    @(posedge aclk);
    input_select <= sel;
    burst(m, 1'b0);
    burst(m, 1'b0);
    count_window <= 1'b1;
    repeat (4) @(posedge aclk);
    // unselected inputs get three extra pulses
    for (int i = 0; i < n + 3; i++) begin
      burst((i < n) ? {NUM_IN{1'b1}} : ~m, 1'b0);
    end
    count_window <= 1'b0;
    repeat (8) @(posedge aclk);
    burst('0, 1'b1);
    readout_cmd <= 1'b1;
    repeat (4) @(posedge aclk);
    for (int b = WORD_W - 1; b >= 0; b--) begin
      @(negedge aclk);
      word[b] = serial_pos;
      if (serial_pos === serial_neg) begin
        pair_ok = 1'b0;
      end
      burst('0, 1'b1);
    end
    readout_cmd <= 1'b0;
  endtask
endmodule

/* radar_data_converter_timing_bench.sv */
// self-checking bench for the radar converter and timing logic
`timescale 1ns/1ns
module radar_data_converter_timing_bench;
  import rdc_pkg::*;
  localparam int MV = 200;
  logic aclk = '0, aresetn = '0, master_osc = '0, ref_clk_3k2 = '0, self_test_sw = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, tilt_cmd = '0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, antenna_selector = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [NUM_IN-1:0] pulse_rate_input;
  logic [SEL_W-1:0] input_select;
  logic count_window, readout_cmd, readout_clk, serial_pos, serial_neg;
  logic osc_speed_up, osc_speed_down, ref_locked, sub_fc, sub_fc_a, sub_fc_b, sub_fc_c;
  logic vel_test_tone, alt_test_tone, drive_pos1, drive_pos2, pos1_ind, pos2_ind, heater_on;
  logic limit_pos1 = 1'h1, limit_pos2 = '0, sense_pos1 = '0, sense_pos2 = '0, main_pwr = '0;
  logic range_good = '0, vel_good = '0, range_scale = '0;
  logic range_valid_ind, vel_valid_ind, range_scale_ind;
  logic [TEMP_W-1:0] antenna_temp = 10'h03C;
  int n_fail = 0;
  int cmp_count = 0;
  rdc_radar_timing #(.MOVE_LIMIT(MV)) u_dut (.*);
  rdc_guidance_model u_gc (.aclk, .pulse_rate_input, .input_select, .count_window,
    .readout_cmd, .readout_clk, .serial_pos, .serial_neg);
  initial forever #25 aclk = ~aclk;
  // reference period is exactly 768 oscillator periods
  initial forever #204 master_osc = ~master_osc;
  initial forever #156672 ref_clk_3k2 = ~ref_clk_3k2;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask
  // handshakes are judged at the negedge, where the slave's ready lines have settled
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h, hr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      h = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (h) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(A_CTRL, d, r);
    chk("ctrl reset", 32'h0, d);
    axw(5'h10, 32'h3, r);
    chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
    axr(5'h14, d, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    axw(A_CTRL, 32'h1, r);
    axr(A_STATUS, d, r);
    chk("status test", 32'h1, 32'(d[1]));
    axw(A_CTRL, 32'h0, r);
  endtask
  // zero after nine shows the counter was cleared between windows
  task automatic t_conv;
    int nn[4] = '{9, 0, 5, 2};
    logic [WORD_W-1:0] w;
    logic ok;
    logic [31:0] d;
    logic [1:0] r;
    for (int s = 0; s < 4; s++) begin
      u_gc.measure(s[1:0], nn[s], w, ok);
      chk("word", 32'(nn[s]), 32'(w));
      chk("pair", 32'h1, 32'(ok));
    end
    axr(A_WORD, d, r);
    chk("word reg", 32'h2, d);
  endtask
  // rises over one fc/64 period, half-open so coincident edges count once
  task automatic rises(output int c[6]);
    logic [6:0] pv, nv;
    bit on;
    on = 1'b0;
    pv = '1;
    c = '{default: 0};
    repeat (6000) begin
      @(negedge aclk);
      nv = {sub_fc_c, master_osc, sub_fc, sub_fc_a, sub_fc_b, vel_test_tone, alt_test_tone};
      if (nv[6] && !pv[6] && on) break;
      if (nv[6] && !pv[6]) on = 1'b1;
      if (on) for (int j = 0; j < 6; j++) c[j] += int'(nv[j] && !pv[j]);
      pv = nv;
    end
  endtask
  task automatic t_ref;
    int c[6];
    int ex[6] = '{2, 1, 2, 16, 64, 256};
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    self_test_sw <= 1'b1;
    settle(13000);
    chk("ref_locked", 32'h1, 32'(ref_locked));
    axr(A_REFMEAS, d, r);
    chk("refmeas", 32'(REF_RATIO), d);
    chk("refmeas rresp", 32'(RESP_OKAY), 32'(r));
    chk("speed", 32'h0, 32'({osc_speed_up, osc_speed_down}));
    rises(c);
    for (int j = 0; j < 6; j++) chk($sformatf("rises%0d", j), 32'(ex[j]), 32'(c[j]));
    @(posedge aclk);
    self_test_sw <= 1'b0;
    settle(6);
    rises(c);
    for (int j = 0; j < 2; j++) chk($sformatf("tone%0d", j), 32'h0, 32'(c[j]));
  endtask
  task automatic t_tilt;
    @(posedge aclk);
    antenna_selector <= SEL_POS2;
    limit_pos1 <= 1'b0;
    settle(6);
    chk("drive", 32'h2, 32'({drive_pos2, drive_pos1}));
    @(posedge aclk);
    limit_pos2 <= 1'b1;
    settle(6);
    chk("drive2", 32'h0, 32'(drive_pos2));
    @(posedge aclk);
    antenna_selector <= SEL_AUTO;
    limit_pos2 <= 1'b0;
    settle(6);
    chk("auto drive", 32'h1, 32'({drive_pos2, drive_pos1}));
    @(posedge aclk);
    tilt_cmd <= 1'b1;
    limit_pos2 <= 1'b1;
    settle(6);
    chk("auto at limit", 32'h0, 32'({drive_pos2, drive_pos1}));
    @(posedge aclk);
    tilt_cmd <= 1'b0;
    settle(MV - 20);
    chk("moving", 32'h1, 32'(drive_pos1));
    settle(30);
    chk("move over", 32'h0, 32'(drive_pos1));
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      sense_pos1 <= !i[0];
      sense_pos2 <= i[0];
      settle(4);
      chk("position ind", 32'(i[0] ? 2'h2 : 2'h1), 32'({pos2_ind, pos1_ind}));
    end
  endtask
  task automatic t_heat;
    logic [TEMP_W-1:0] tt[7] = '{10'h032, 10'h03C, 10'h046, 10'h03C, 10'h037, 10'h037, 10'h037};
    logic [6:0] pp = 7'h20;
    logic [6:0] ee = 7'h53;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) begin
      @(posedge aclk);
      antenna_temp <= tt[i];
      main_pwr <= pp[i];
      settle(6);
      chk("heater", 32'(ee[i]), 32'(heater_on));
    end
    axw(A_CTRL, 32'h2, r);
    chk("inhibit bresp", 32'(RESP_OKAY), 32'(r));
    settle(2);
    chk("heater inhibit", 32'h0, 32'(heater_on));
    axw(A_CTRL, 32'h0, r);
  endtask
  task automatic t_disc;
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      range_good <= i[0];
      vel_good <= !i[0];
      range_scale <= i[0];
      settle(4);
      chk("status ind", 32'(i[0] ? 3'h5 : 3'h2),
        32'({range_scale_ind, vel_valid_ind, range_valid_ind}));
    end
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_conv();
    t_ref();
    t_tilt();
    t_heat();
    t_disc();
    conclude();
  end
  // the whole run needs about 1.1 ms
  initial begin
    #3000000;
    n_fail++;
    conclude();
  end
endmodule
